/* design/intr_bus_status_pkg.sv */
// Constants and types for the interrupt bus status cycle decoder
package intr_bus_status_pkg;

  // Delivery modes as carried in the message mode field
  typedef enum logic [2:0] {
    DLV_FIXED    = 3'h0,
    DLV_LOWEST   = 3'h1,
    DLV_SYSMGMT  = 3'h2,
    DLV_EOI      = 3'h3,
    DLV_NMI      = 3'h4,
    DLV_INIT     = 3'h5,
    DLV_STARTUP  = 3'h6,
    DLV_EXTVEC   = 3'h7
  } delivery_mode_e;

  // Decoded outcome
  typedef enum logic [2:0] {
    OUT_ACCEPT       = 3'h0,
    OUT_RETRY        = 3'h1,
    OUT_ACCEPT_ERROR = 3'h2,
    OUT_CS_ERROR     = 3'h3,
    OUT_ERROR        = 3'h4,
    OUT_END_RETRY    = 3'h5,
    OUT_FOCUS        = 3'h6,
    OUT_ARB_ERROR    = 3'h7
  } outcome_e;

  // Sequencer states, Gray from ST_IDLE through ST_RUN to ST_DONE
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } seq_state_e;

  // Flag pair encodings
  localparam logic [1:0] PAIR_OK    = 2'h0;
  localparam logic [1:0] PAIR_LOW   = 2'h1;
  localparam logic [1:0] PAIR_FOCUS = 2'h2;
  localparam logic [1:0] PAIR_ALL   = 2'h3;

  // Cycle numbers within a message
  localparam logic [5:0] CYC_FIRST   = 6'h01;
  localparam logic [5:0] CYC_STATUS0 = 6'h13;
  localparam logic [5:0] CYC_STATUS1 = 6'h14;
  localparam logic [5:0] CYC_STATUS2 = 6'h21;
  localparam logic [5:0] CYC_UPD_EOI = 6'h0D;
  localparam logic [5:0] CYC_UPD_STD = 6'h14;
  localparam logic [5:0] CYC_EOI_ACC = 6'h0C;

  // Message lengths
  localparam logic [5:0] LEN_EOI     = 6'h0E;
  localparam logic [5:0] LEN_SHORT   = 6'h15;
  localparam logic [5:0] LEN_LOWEST  = 6'h22;
  localparam logic [5:0] LEN_NONE    = 6'h00;

endpackage

/* design/intr_bus_status_decoder.sv */
// Status cycle decoder for the shared two-wire interrupt message bus
`timescale 1ns/10ps

module intr_bus_status_decoder
  import intr_bus_status_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              msg_start,
  input  wire intr_bus_status_pkg::delivery_mode_e delivery_mode,
  input  wire logic [1:0]                        bus_pair,
  input  wire logic                              arb_won,
  output logic                                   status2_drive_en,
  output logic                                   result_valid,
  output intr_bus_status_pkg::outcome_e          outcome,
  output logic [5:0]                             message_length,
  output logic                                   update_arbitration_id,
  output logic [5:0]                             update_cycle,
  output logic                                   retry,
  output logic                                   focus_absent,
  output logic                                   arbitration_id_strobe,
  output logic [5:0]                             bus_cycle
);
  import intr_bus_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; pair from the wire is async to clk
  logic [1:0] pair_meta_q;
  logic [1:0] pair_sync_q;
  logic       start_meta_q;
  logic       start_sync_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pair_meta_q  <= PAIR_OK;
      pair_sync_q  <= PAIR_OK;
      start_meta_q <= 1'b0;
      start_sync_q <= 1'b0;
    end
    else
    begin
      pair_meta_q  <= bus_pair;
      pair_sync_q  <= pair_meta_q;
      start_meta_q <= msg_start;
      start_sync_q <= start_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode function, shared for all status points
  typedef struct packed {
    outcome_e   res;
    logic [5:0] len;
    logic       upd;
    logic [5:0] ucyc;
    logic       rty;
  } decision_s;

  function automatic decision_s decide(input delivery_mode_e mode, input logic [1:0] cs,
                                       input logic [1:0] acc, input logic [1:0] arb);
    decision_s d;
    logic      eoi;
    eoi    = (mode == DLV_EOI);
    d.len  = eoi ? LEN_EOI : LEN_SHORT;
    d.ucyc = eoi ? CYC_UPD_EOI : CYC_UPD_STD;
    d.res  = OUT_ERROR;
    d.upd  = 1'b0;
    d.rty  = 1'b1;
    if (mode == DLV_LOWEST)
    begin
      case (cs)
        PAIR_FOCUS:
        begin
          d.res = OUT_FOCUS;
          d.len = LEN_LOWEST;
          d.upd = 1'b1;
          d.rty = 1'b0;
        end
        PAIR_OK:
        begin
          d.len = LEN_LOWEST;
          if (!acc[1])
            d.res = OUT_ACCEPT_ERROR;
          else if (!acc[0])
          begin
            d.res = OUT_END_RETRY;
            d.upd = 1'b1;
          end
          else if (arb == PAIR_FOCUS)
          begin
            d.res = OUT_ACCEPT;
            d.upd = 1'b1;
            d.rty = 1'b0;
          end
          else
          begin
            d.res = OUT_ARB_ERROR;
            d.upd = 1'b1;
          end
        end
        PAIR_ALL:
          d.res = OUT_CS_ERROR;
        default:
          d.res = OUT_ERROR;
      endcase
    end
    else
    begin
      case (cs)
        PAIR_OK:
        begin
          if (!acc[1])
            d.res = OUT_ACCEPT_ERROR;
          else if (acc[0])
          begin
            d.res = OUT_RETRY;
            d.upd = 1'b1;
          end
          else
          begin
            d.res = OUT_ACCEPT;
            d.upd = 1'b1;
            d.rty = 1'b0;
          end
        end
        PAIR_ALL:
          d.res = OUT_CS_ERROR;
        default:
          d.res = OUT_ERROR;
      endcase
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Message sequencer
  seq_state_e     state_q, state_d;
  logic [5:0]     cyc_q, cyc_d;
  delivery_mode_e mode_q, mode_d;
  logic [1:0]     cs_q, cs_d;
  logic [1:0]     acc_q, acc_d;
  logic [1:0]     arb_q, arb_d;
  decision_s      dec_q, dec_d;
  logic           valid_q, valid_d;
  logic           drive_q, drive_d;
  logic           strobe_q, strobe_d;
  decision_s      now;
  logic [5:0]     acc_cycle;
  logic [1:0]     acc_now;

  always_comb
  begin
    state_d  = state_q;
    cyc_d    = cyc_q;
    mode_d   = mode_q;
    cs_d     = cs_q;
    acc_d    = acc_q;
    arb_d    = arb_q;
    dec_d    = dec_q;
    valid_d  = 1'b0;
    drive_d  = 1'b0;
    strobe_d = 1'b0;
    // EOI status falls earlier, at the end of its short frame
    acc_cycle = (mode_q == DLV_EOI) ? CYC_EOI_ACC : CYC_STATUS1;
    // Live pair in the acceptance cycle; the stored one is still stale there
    acc_now = (state_q == ST_RUN && cyc_q == acc_cycle) ? pair_sync_q : acc_q;
    now = decide(mode_q, cs_q, acc_now, arb_q);
    case (state_q)
      ST_IDLE:
      begin
        if (start_sync_q)
        begin
          state_d = ST_RUN;
          cyc_d   = CYC_FIRST;
          mode_d  = delivery_mode;
        end
      end
      ST_RUN:
      begin
        cyc_d = cyc_q + 6'h01;
        if (cyc_q == ((mode_q == DLV_EOI) ? CYC_EOI_ACC - 6'h01 : CYC_STATUS0))
          cs_d = pair_sync_q;
        if (cyc_q == acc_cycle)
          acc_d = pair_sync_q;
        if (cyc_q == CYC_STATUS2)
          arb_d = pair_sync_q;
        if (cyc_q == CYC_STATUS2 - 6'h01 && now.len == LEN_LOWEST && cs_q == PAIR_OK && acc_q == PAIR_ALL)
          drive_d = arb_won;
        if (cyc_q >= now.len && cyc_q > acc_cycle)
        begin
          state_d  = ST_DONE;
          dec_d    = now;
          valid_d  = 1'b1;
        end
        if (now.upd && cyc_q == now.ucyc && cyc_q > acc_cycle - 6'h01)
          strobe_d = 1'b1;
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
        cyc_d   = LEN_NONE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q  <= ST_IDLE;
      cyc_q    <= LEN_NONE;
      mode_q   <= DLV_FIXED;
      cs_q     <= PAIR_OK;
      acc_q    <= PAIR_OK;
      arb_q    <= PAIR_OK;
      dec_q    <= '0;
      valid_q  <= 1'b0;
      drive_q  <= 1'b0;
      strobe_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cyc_q    <= cyc_d;
      mode_q   <= mode_d;
      cs_q     <= cs_d;
      acc_q    <= acc_d;
      arb_q    <= arb_d;
      dec_q    <= dec_d;
      valid_q  <= valid_d;
      drive_q  <= drive_d;
      strobe_q <= strobe_d;
    end
  end

  assign status2_drive_en      = drive_q;
  assign result_valid          = valid_q;
  assign outcome               = dec_q.res;
  assign message_length        = dec_q.len;
  assign update_arbitration_id = dec_q.upd;
  assign update_cycle          = dec_q.ucyc;
  assign retry                 = dec_q.rty;
  assign focus_absent          = (mode_q == DLV_LOWEST) && (cs_q == PAIR_OK);
  assign arbitration_id_strobe = strobe_q;
  assign bus_cycle             = cyc_q;

endmodule

/* tb/intr_bus_status_chk.sv */
// Checker of the status decoder outputs
`timescale 1ns/10ps
module intr_bus_status_chk
  import intr_bus_status_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic                          result_valid,
  input wire intr_bus_status_pkg::outcome_e outcome,
  input wire logic [5:0]                    message_length,
  input wire logic                          update_arbitration_id,
  input wire logic [5:0]                    update_cycle,
  input wire logic                          retry,
  input wire logic                          arbitration_id_strobe,
  input wire logic                          status2_drive_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  a_pulse_once:
    assert property (result_valid |=> !result_valid) else $error("long valid");
  a_err_no_upd:
    assert property (result_valid && outcome inside {OUT_ACCEPT_ERROR, OUT_CS_ERROR, OUT_ERROR}
      |-> retry && !update_arbitration_id) else $error("error updated id");
  a_accept_no_retry:
    assert property (result_valid && outcome inside {OUT_ACCEPT, OUT_FOCUS} |-> !retry && update_arbitration_id)
      else $error("accept retried");
  a_arb_err_upd:
    assert property (result_valid && outcome inside {OUT_ARB_ERROR, OUT_END_RETRY}
      |-> retry && update_arbitration_id && message_length == LEN_LOWEST) else $error("arb error");
  a_upd_cycle:
    assert property (result_valid && update_arbitration_id
      |-> update_cycle == (message_length == LEN_EOI ? CYC_UPD_EOI : CYC_UPD_STD)) else $error("update cycle");
  a_strobe_ahead:
    assert property (arbitration_id_strobe |-> ##[1:22] result_valid && update_arbitration_id) else $error("strobe");
  a_drive_ahead:
    assert property (status2_drive_en |-> ##[1:4] result_valid && message_length == LEN_LOWEST) else $error("drive");
  a_result_holds:
    assert property (!result_valid |-> $stable(outcome) && $stable(retry)) else $error("result moved");
  c_accept: cover property (result_valid && outcome == OUT_ACCEPT);
  c_arb_err: cover property (result_valid && outcome == OUT_ARB_ERROR);
  c_drive: cover property (status2_drive_en);
endmodule
////////////////////////////////////////
bind intr_bus_status_decoder intr_bus_status_chk chk (.clk, .reset, .result_valid, .outcome, .message_length,
  .update_arbitration_id, .update_cycle, .retry, .arbitration_id_strobe, .status2_drive_en);

/* tb/intr_bus_peer.sv */
// Peer controller model driving the flag pairs
`timescale 1ns/10ps
module intr_bus_peer
  import intr_bus_status_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic [5:0]                          bus_cycle,
  input  wire intr_bus_status_pkg::delivery_mode_e delivery_mode,
  input  wire logic [1:0]                          cs,
  input  wire logic [1:0]                          acc,
  input  wire logic [1:0]                          arb,
  output logic [1:0]                               bus_pair
);
  logic [5:0] c;
  initial bus_pair = 2'h0;
  // Two cycles ahead to cover the synchroniser
  always @(negedge clk)
  begin
    c = bus_cycle + 6'h02;
    if (c == (delivery_mode == DLV_EOI ? 6'h0B : CYC_STATUS0))
      bus_pair <= cs;
    else if (c == (delivery_mode == DLV_EOI ? CYC_EOI_ACC : CYC_STATUS1))
      bus_pair <= acc;
    else if (c == CYC_STATUS2)
      bus_pair <= arb;
    // Toggle so a stale pair never looks valid
    else
      bus_pair <= ~bus_pair;
  end
endmodule

/* tb/tb_intr_bus_status_decoder.sv */
// Self-checking testbench for the status decoder
`timescale 1ns/10ps
module tb_intr_bus_status_decoder;
  import intr_bus_status_pkg::*;
  logic           clk = 1'h0;
  logic           reset = 1'h1;
  logic           msg_start = 1'h0;
  logic           arb_won = 1'h0;
  delivery_mode_e delivery_mode = DLV_FIXED;
  logic [1:0]     cs = 2'h0;
  logic [1:0]     acc = 2'h0;
  logic [1:0]     arb = 2'h0;
  logic [1:0]     bus_pair;
  logic           status2_drive_en, result_valid, update_arbitration_id, retry, focus_absent, arbitration_id_strobe;
  outcome_e       outcome;
  logic [5:0]     message_length, update_cycle, bus_cycle;
  int             n_errors = 0;
  int             n_checks = 0;
  always #50 clk = ~clk;
  intr_bus_status_decoder uut (.clk, .reset, .msg_start, .delivery_mode, .bus_pair, .arb_won, .status2_drive_en,
    .result_valid, .outcome, .message_length, .update_arbitration_id, .update_cycle, .retry, .focus_absent,
    .arbitration_id_strobe, .bus_cycle);
  intr_bus_peer peer (.clk, .bus_cycle, .delivery_mode, .cs, .acc, .arb, .bus_pair);
  ////////////////////////////////////////
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One message; length and drive expected from mode and pairs
  task automatic run(input delivery_mode_e m, input logic [1:0] c, a, r, input logic w, input outcome_e o,
                     input logic u, rt);
    logic [5:0] el;
    logic       dr;
    logic       sb;
    el = m == DLV_EOI ? LEN_EOI : (m == DLV_LOWEST && !c[0]) ? LEN_LOWEST : LEN_SHORT;
    dr = 1'h0;
    sb = 1'h0;
    @(negedge clk);
    delivery_mode = m;
    cs = c;
    acc = a;
    arb = r;
    arb_won = w;
    msg_start = 1'h1;
    @(negedge clk);
    msg_start = 1'h0;
    for (int i = 0; i < 60 && result_valid !== 1'h1; i++)
    begin
      @(negedge clk);
      dr |= status2_drive_en;
      sb |= arbitration_id_strobe;
    end
    if (result_valid !== 1'h1)
    begin
      n_errors++;
      end_of_test();
    end
    check({14'h0000, bus_cycle}, {14'h0000, el + 6'h01});
    check({outcome, message_length, update_arbitration_id, retry, focus_absent, dr, sb, u ? update_cycle : 6'h00},
          {o, el, u, rt, m == DLV_LOWEST && c == 2'h0, m == DLV_LOWEST && c == 2'h0 && a == 2'h3 && w, u,
           u ? (m == DLV_EOI ? CYC_UPD_EOI : CYC_UPD_STD) : 6'h00});
    @(negedge clk);
  endtask
  task automatic t_nonlowest(input delivery_mode_e m);
    run(m, 2'h0, 2'h2, 2'h1, 1'h1, OUT_ACCEPT, 1'h1, 1'h0);
    run(m, 2'h0, 2'h3, 2'h1, 1'h1, OUT_RETRY, 1'h1, 1'h1);
    run(m, 2'h0, 2'h1, 2'h2, 1'h0, OUT_ACCEPT_ERROR, 1'h0, 1'h1);
    run(m, 2'h3, 2'h2, 2'h1, 1'h0, OUT_CS_ERROR, 1'h0, 1'h1);
    run(m, 2'h2, 2'h2, 2'h1, 1'h0, OUT_ERROR, 1'h0, 1'h1);
    run(m, 2'h1, 2'h0, 2'h3, 1'h0, OUT_ERROR, 1'h0, 1'h1);
  endtask
  task automatic t_lowest();
    run(DLV_LOWEST, 2'h0, 2'h3, 2'h2, 1'h1, OUT_ACCEPT, 1'h1, 1'h0);
    run(DLV_LOWEST, 2'h0, 2'h3, 2'h3, 1'h0, OUT_ARB_ERROR, 1'h1, 1'h1);
    run(DLV_LOWEST, 2'h0, 2'h3, 2'h1, 1'h1, OUT_ARB_ERROR, 1'h1, 1'h1);
    run(DLV_LOWEST, 2'h0, 2'h2, 2'h2, 1'h1, OUT_END_RETRY, 1'h1, 1'h1);
    run(DLV_LOWEST, 2'h0, 2'h0, 2'h2, 1'h1, OUT_ACCEPT_ERROR, 1'h0, 1'h1);
    run(DLV_LOWEST, 2'h2, 2'h1, 2'h3, 1'h1, OUT_FOCUS, 1'h1, 1'h0);
    run(DLV_LOWEST, 2'h3, 2'h3, 2'h2, 1'h1, OUT_CS_ERROR, 1'h0, 1'h1);
    run(DLV_LOWEST, 2'h1, 2'h3, 2'h2, 1'h1, OUT_ERROR, 1'h0, 1'h1);
  endtask
  // Reset in mid-frame clears all outputs, then a frame decodes again
  task automatic t_reset();
    @(negedge clk);
    delivery_mode = DLV_LOWEST;
    cs = 2'h0;
    acc = 2'h3;
    arb = 2'h2;
    arb_won = 1'h1;
    msg_start = 1'h1;
    @(negedge clk);
    msg_start = 1'h0;
    repeat (30) @(negedge clk);
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    check({2'h0, result_valid, outcome, message_length, update_arbitration_id, update_cycle, retry}, 20'h00000);
    check({11'h000, status2_drive_en, arbitration_id_strobe, focus_absent, bus_cycle}, 20'h00000);
    run(DLV_LOWEST, 2'h0, 2'h3, 2'h2, 1'h1, OUT_ACCEPT, 1'h1, 1'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    delivery_mode_e m;
    repeat (5) @(negedge clk);
    reset = 1'h0;
    t_lowest();
    m = m.first();
    repeat (8)
    begin
      if (m != DLV_LOWEST)
        t_nonlowest(m);
      m = m.next();
    end
    t_reset();
    end_of_test();
  end
endmodule
